// File: msr_pkg.sv
/*
 * msr_pkg: field layout, codes and widths of the search result header.
 * assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package msr_pkg;
    // number of dwords in the header phase
    localparam int unsigned DW_COUNT = 8;
    // field positions
    localparam int unsigned STALL_LSB     = 16;
    localparam int unsigned COMPUTE_LSB   = 0;
    localparam int unsigned ALT_LEN_LSB   = 26;
    localparam int unsigned MVLIM_BIT     = 25;
    localparam int unsigned ESTOP_BIT     = 24;
    localparam int unsigned PRED_LSB      = 16;
    localparam int unsigned SHAPE_LSB     = 8;
    localparam int unsigned NBR_LSB       = 0;
    localparam int unsigned SKIP_LSB      = 16;
    localparam int unsigned INTER_LSB     = 0;
    localparam int unsigned REF1SUM_LSB   = 16;
    localparam int unsigned PATH_LSB      = 8;
    localparam int unsigned BORDER1_LSB   = 4;
    localparam int unsigned BORDER0_LSB   = 0;
    localparam int unsigned MVCNT_LSB     = 24;
    localparam int unsigned UNPACK_BIT    = 23;
    localparam int unsigned INTRA_TY_LSB  = 16;
    localparam int unsigned XFORM_BIT     = 15;
    localparam int unsigned FIELD_BIT     = 14;
    localparam int unsigned INTER_TY_LSB  = 8;
    localparam int unsigned CHROMA_LSB    = 16;
    localparam int unsigned INTRA_D_LSB   = 0;
    // limits and masks
    localparam logic [5:0] ALT_LEN_MAX    = 6'h30;
    localparam logic [5:0] MVCNT_MAX      = 6'h20;
    localparam logic [7:0] NBR_MASK       = 8'h3f;
    localparam logic [1:0] INTRA_OFF_MSB  = 2'h2;
    localparam logic [1:0] LUMA16_MASK    = 2'h3;
    localparam logic [3:0] ZERO_NIB       = 4'h0;
    localparam int unsigned REF1SUM_SHIFT = 16;

    typedef enum logic [1:0] {
        MSR_PART_16X16,
        MSR_PART_16X8,
        MSR_PART_8X16,
        MSR_PART_8X8
    } msr_part_e;

    typedef enum logic [1:0] {
        MSR_IMODE_16X16,
        MSR_IMODE_8X8,
        MSR_IMODE_4X4,
        MSR_IMODE_RSVD
    } msr_imode_e;

    typedef enum logic [1:0] {
        MSR_ST_IDLE,
        MSR_ST_RUN,
        MSR_ST_DONE
    } msr_state_e;

    // per-request search outcome handed in by the engine datapath
    typedef struct packed {
        logic [5:0]  alt_path_units;
        logic [7:0]  path_units;
        logic        mv_limit_hit;
        logic        early_stop_hit;
        msr_part_e   inter_partition_mode;
        msr_imode_e  intra_partition_mode;
        logic        intra_block_flag;
        logic        dual_path;
        logic        luma_16x16;
        logic        any_sub_lt_8x8;
        logic [7:0]  sub_partition_pred_modes;
        logic [7:0]  sub_partition_shapes;
        logic [15:0] chroma_dist_cb;
        logic [15:0] chroma_dist_cr;
        logic [15:0] best_intra_dist;
        logic [15:0] skip_raw_dist;
        logic [15:0] best_inter_dist;
        logic [26:0] ref1_distortion_sum;
        logic [3:0]  border_ref0;
        logic [3:0]  border_ref1;
        logic [5:0]  motion_vector_count;
        logic [4:0]  intra_block_type_code;
        logic [4:0]  inter_block_type_code;
        logic [63:0] luma_pred_modes;
    } msr_result_s;

    // request options copied or used from the input message
    typedef struct packed {
        logic [7:0] neighbor_avail_mask;
        logic [1:0] intra_compute_select;
        logic       skip_eval_enable;
        logic       large_transform_inter_enable;
        logic       source_field_access;
    } msr_request_s;
endpackage : msr_pkg
`default_nettype wire

// File: msr_clock_counter.sv
/*
 * msr_clock_counter: saturating per-request cycle counter.
 * assumes clear and count are synchronous to core_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module msr_clock_counter #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             core_clk, // engine clock
    input  wire logic             arst_n,   // async reset, low
    input  wire logic             clear,    // restart at zero
    input  wire logic             count,    // add one this cycle
    output logic [WIDTH-1:0]      value     // running count
);
    // saturate so a long request never wraps to a small figure
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            value <= '0;
        end else if (clear) begin
            value <= '0;
        end else if (count && (value != {WIDTH{1'b1}})) begin
            value <= value + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule : msr_clock_counter
`default_nettype wire

// File: msr_header.sv
/*
 * msr_header: builds result phase 0 (eight dwords) of a motion search
 * return message. the engine pulses start, then reports busy cycles with
 * stall marking, then pulses done with the outcome and request options.
 * assumes all inputs except the async reset arst_n are synchronous to core_clk.
 */
// Notes on behaviour
// [RQ1] w0.7 31:16 counts stalled or cache-starved cycles of this request
// [RQ2] w0.7 15:0 counts active, unstalled processing cycles
// [RQ3] w0.6 31:26 second-path unique search units, zero for single path
// [RQ4] w0.6 bit 25 set when vector limit rejected best; 16x16 source only
// [RQ5] w0.6 bit 24 set when early stop ended the integer search
// [RQ6] w0.6 23:16 four sub-partition prediction modes, unused bits zero
// [RQ7] w0.6 15:8 sub-partition shapes, zero unless 8x8 partitioning
// [RQ8] w0.6 7:0 neighbour byte copied from the request
// [RQ9] neighbour byte bits 7:6 zero, whole byte zero when intra disabled
// [RQ10] w0.4/w0.5 four luma mode words, zero when intra disabled
// [RQ11] 16x16 intra luma modes carry only two meaningful low bits
// [RQ12] w0.3 31:16 chroma distortion cb plus cr, zero intra disabled
// [RQ13] w0.2 31:16 skip raw distortion, zero when skip not enabled
// [RQ14] w0.2 15:0 best inter distortion
// [RQ15] w0.1 26:16 top eleven bits of reference 1 distortion sum
// [RQ16] w0.1 15:8 total search units of both paths
// [RQ17] w0.1 7:4 ref1 and 3:0 ref0 border masks of the winner
// [RQ18] w0.0 28:24 packed motion vector count, zero to 32; a count of 32 reads as zero
// [RQ19] w0.0 bit 23 reads zero; output always unpacked
// [RQ20] w0.0 20:16 intra block type code, zero when intra disabled
// [RQ21] w0.0 bit 15 8x8 transform choice, zero for non-16x16 source
// [RQ22] w0.0 bit 14 copies source field access
// [RQ23] kernel ignores fields not valid for its message type
`timescale 1ns/10ps
`default_nettype none
module msr_header #(
    parameter int unsigned CNT_W = 16
) (
    input  wire logic                 core_clk, // engine clock
    input  wire logic                 arst_n,   // async reset, low
    input  wire logic                 start,    // request accepted
    input  wire logic                 busy,     // engine working
    input  wire logic                 stalled,  // cache miss stall
    input  wire logic                 done,     // outcome valid
    input  wire msr_pkg::msr_result_s result,   // search outcome
    input  wire msr_pkg::msr_request_s req,     // request options
    output logic [255:0]              phase0,   // dwords 7..0
    output logic                      phase0_valid, // one-cycle pulse
    output logic                      counting  // request in flight
);
    import msr_pkg::*;

    msr_state_e       state_r;
    logic [CNT_W-1:0] stall_cnt;
    logic [CNT_W-1:0] comp_cnt;
    logic             intra_off;
    logic [31:0]      w7_nxt, w6_nxt, w3_nxt, w2_nxt, w1_nxt, w0_nxt;
    logic [63:0]      luma_nxt;
    logic [16:0]      chroma_sum;
    logic [7:0]       nbr_nxt;
    logic [7:0]       pred_nxt;
    logic [5:0]       alt_nxt;
    logic [4:0]       mvcnt_nxt;
    logic             xform_nxt;
    logic             in_req;

    assign in_req = (state_r == MSR_ST_RUN);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= MSR_ST_IDLE;
        end else begin
            case (state_r)
                MSR_ST_IDLE: if (start) state_r <= MSR_ST_RUN;
                MSR_ST_RUN:  if (done)  state_r <= MSR_ST_DONE;
                MSR_ST_DONE: state_r <= start ? MSR_ST_RUN : MSR_ST_IDLE;
                default:     state_r <= MSR_ST_IDLE;
            endcase
        end
    end

    msr_clock_counter #(.WIDTH(CNT_W)) u_stall (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .clear    (start),
        .count    (in_req && busy && stalled),   // RQ1
        .value    (stall_cnt)
    );

    msr_clock_counter #(.WIDTH(CNT_W)) u_comp (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .clear    (start),
        .count    (in_req && busy && !stalled),  // RQ2
        .value    (comp_cnt)
    );

    // intra disabled when the select's upper bit is set (1x)
    assign intra_off = (req.intra_compute_select & INTRA_OFF_MSB) != 2'h0;

    always_comb begin
        nbr_nxt = req.neighbor_avail_mask & NBR_MASK; // RQ8 RQ9
        if (intra_off) nbr_nxt = 8'h00; // RQ9
        alt_nxt = result.dual_path ? result.alt_path_units : 6'h00; // RQ3
        if (alt_nxt > ALT_LEN_MAX) alt_nxt = ALT_LEN_MAX;
        case (result.inter_partition_mode) // RQ6
            MSR_PART_16X16:
                pred_nxt = {6'h00, result.sub_partition_pred_modes[1:0]};
            MSR_PART_16X8,
            MSR_PART_8X16:
                pred_nxt = {4'h0, result.sub_partition_pred_modes[3:0]};
            default: pred_nxt = result.sub_partition_pred_modes;
        endcase
        w7_nxt = {stall_cnt[15:0], comp_cnt[15:0]}; // RQ1 RQ2
        w6_nxt = {alt_nxt,
                  result.mv_limit_hit && result.luma_16x16, // RQ4
                  result.early_stop_hit, // RQ5
                  pred_nxt,
                  (result.inter_partition_mode == MSR_PART_8X8)
                      ? result.sub_partition_shapes : 8'h00, // RQ7
                  nbr_nxt};
        luma_nxt = result.luma_pred_modes;
        if (intra_off) begin
            luma_nxt = 64'h0; // RQ10
        end else if (result.intra_block_flag &&
                     result.intra_partition_mode == MSR_IMODE_16X16) begin
            // only four 16x16 modes, so upper bits would be noise
            luma_nxt = {14'h0, result.luma_pred_modes[49:48], // RQ11
                        14'h0, result.luma_pred_modes[33:32],
                        14'h0, result.luma_pred_modes[17:16],
                        14'h0, result.luma_pred_modes[1:0]};
        end
        chroma_sum = {1'b0, result.chroma_dist_cb} +
                     {1'b0, result.chroma_dist_cr};
        // saturate rather than wrap so a huge sum still ranks as poor
        w3_nxt = {(chroma_sum[16] ? 16'hffff : chroma_sum[15:0]), // RQ12
                  result.best_intra_dist};
        if (intra_off) w3_nxt = 32'h0; // RQ12
        w2_nxt = {req.skip_eval_enable ? result.skip_raw_dist : 16'h0, // RQ13
                  result.best_inter_dist}; // RQ14
        w1_nxt = {5'h00,
                  result.ref1_distortion_sum[26:REF1SUM_SHIFT], // RQ15
                  result.path_units, // RQ16
                  result.border_ref1, result.border_ref0}; // RQ17
        // a count beyond the five-bit range reads as zero
        mvcnt_nxt = (result.motion_vector_count > MVCNT_MAX)
                    ? 5'h00 : result.motion_vector_count[4:0]; // RQ18
        if (!result.luma_16x16) begin
            xform_nxt = 1'b0; // RQ21
        end else if (result.intra_block_flag) begin
            xform_nxt = result.intra_partition_mode == MSR_IMODE_8X8;
        end else begin
            xform_nxt = req.large_transform_inter_enable &&
                        !result.any_sub_lt_8x8;
        end
        w0_nxt = {3'h0, mvcnt_nxt,
                  1'b0, // RQ19
                  2'h0,
                  intra_off ? 5'h00 : result.intra_block_type_code, // RQ20
                  xform_nxt,
                  req.source_field_access, // RQ22
                  1'b0,
                  result.inter_block_type_code,
                  ZERO_NIB, ZERO_NIB};
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase0       <= '0;
            phase0_valid <= 1'b0;
        end else begin
            phase0_valid <= in_req && done;
            if (in_req && done) begin
                phase0 <= {w7_nxt, w6_nxt, luma_nxt, w3_nxt, w2_nxt,
                           w1_nxt, w0_nxt};
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            counting <= 1'b0;
        end else begin
            counting <= (state_r == MSR_ST_RUN) ? !done : start;
        end
    end

    property p_stall_count;                                         // RQ1
        @(posedge core_clk) disable iff (!arst_n)
        (in_req && busy && stalled && !start && stall_cnt != 16'hffff)
            |=> stall_cnt == $past(stall_cnt) + 16'h1;
    endproperty
    a_stall_count: assert property (p_stall_count) // RQ1
        else $error("stall count missed a stalled cycle");

    property p_comp_hold;                                           // RQ2
        @(posedge core_clk) disable iff (!arst_n)
        (in_req && stalled && !start) |=> $stable(comp_cnt);
    endproperty
    a_comp_hold: assert property (p_comp_hold) // RQ2
        else $error("compute count moved during a stall");

    sequence s_finish;
        in_req && done;
    endsequence

    property p_w7;                                                  // RQ1
        @(posedge core_clk) disable iff (!arst_n)
        s_finish |=> phase0[255:224] == {$past(stall_cnt), $past(comp_cnt)};
    endproperty
    a_w7: assert property (p_w7) // RQ1 RQ2
        else $error("counter dword mismatch");

    property p_alt_single;                                          // RQ3
        @(posedge core_clk) disable iff (!arst_n)
        (s_finish and !result.dual_path) |=> phase0[223:218] == 6'h00;
    endproperty
    a_alt_single: assert property (p_alt_single) // RQ3
        else $error("alternate path length nonzero for single path");

    property p_shape_zero;                                          // RQ7
        @(posedge core_clk) disable iff (!arst_n)
        (s_finish and result.inter_partition_mode != MSR_PART_8X8)
            |=> phase0[207:200] == 8'h00;
    endproperty
    a_shape_zero: assert property (p_shape_zero) // RQ7
        else $error("shapes not zero outside 8x8 partitioning");

    property p_intra_off;                                           // RQ10
        @(posedge core_clk) disable iff (!arst_n)
        (s_finish and intra_off)
            |=> phase0[191:128] == 64'h0 && phase0[199:192] == 8'h00
                && phase0[127:112] == 16'h0 && phase0[20:16] == 5'h00;
    endproperty
    a_intra_off: assert property (p_intra_off) // RQ9 RQ10 RQ12 RQ20
        else $error("intra fields not zero with intra disabled");

    property p_skip_off;                                            // RQ13
        @(posedge core_clk) disable iff (!arst_n)
        (s_finish and !req.skip_eval_enable) |=> phase0[95:80] == 16'h0;
    endproperty
    a_skip_off: assert property (p_skip_off) // RQ13
        else $error("skip distortion nonzero with skip disabled");

    property p_xform_src;                                           // RQ21
        @(posedge core_clk) disable iff (!arst_n)
        (s_finish and !result.luma_16x16) |=> !phase0[15];
    endproperty
    a_xform_src: assert property (p_xform_src) // RQ21
        else $error("transform flag set for non 16x16 source");

    property p_field;                                               // RQ22
        @(posedge core_clk) disable iff (!arst_n)
        s_finish |=> phase0[14] == $past(req.source_field_access)
                     && !phase0[23] && phase0_valid;
    endproperty
    a_field: assert property (p_field) // RQ19 RQ22
        else $error("field flag or unpacked flag wrong");

    sequence s_pulse;
        phase0_valid ##1 !phase0_valid;
    endsequence

    property p_pulse;
        @(posedge core_clk) disable iff (!arst_n)
        s_finish |=> s_pulse;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("header valid is not a one-cycle pulse");

    property p_clear;
        @(posedge core_clk) disable iff (!arst_n)
        start |=> stall_cnt == '0 && comp_cnt == '0;
    endproperty
    a_clear: assert property (p_clear) // RQ1 RQ2
        else $error("cycle counters not cleared by start");

    property p_mvlim;
        @(posedge core_clk) disable iff (!arst_n)
        (s_finish and !result.luma_16x16) |=> !phase0[217];
    endproperty
    a_mvlim: assert property (p_mvlim) // RQ4
        else $error("vector limit flag set for non 16x16 source");

    property p_estop;
        @(posedge core_clk) disable iff (!arst_n)
        s_finish |=> phase0[216] == $past(result.early_stop_hit);
    endproperty
    a_estop: assert property (p_estop) // RQ5
        else $error("early stop flag not reported");

    property p_pred_unused;
        @(posedge core_clk) disable iff (!arst_n)
        (s_finish and result.inter_partition_mode != MSR_PART_8X8)
            |=> phase0[215:212] == 4'h0;
    endproperty
    a_pred_unused: assert property (p_pred_unused) // RQ6
        else $error("unused prediction mode bits not zero");

    property p_nbr;
        @(posedge core_clk) disable iff (!arst_n)
        (s_finish and !intra_off)
            |=> phase0[199:198] == 2'h0
                && phase0[197:192] == $past(req.neighbor_avail_mask[5:0]);
    endproperty
    a_nbr: assert property (p_nbr) // RQ8 RQ9
        else $error("neighbour byte not copied");

    sequence s_luma16;
        in_req && done && result.intra_block_flag
            && result.intra_partition_mode == MSR_IMODE_16X16;
    endsequence

    property p_luma16;
        @(posedge core_clk) disable iff (!arst_n)
        s_luma16 |=> (phase0[191:128] & {4{16'hfffc}}) == 64'h0;
    endproperty
    a_luma16: assert property (p_luma16) // RQ11
        else $error("16x16 luma modes carry upper bits");

    property p_mvcnt;
        @(posedge core_clk) disable iff (!arst_n)
        (s_finish and result.motion_vector_count > MVCNT_MAX)
            |=> phase0[31:24] == 8'h00;
    endproperty
    a_mvcnt: assert property (p_mvcnt) // RQ18
        else $error("vector count out of range not zeroed");
endmodule : msr_header
`default_nettype wire

// File: msr_kernel_model.sv
/*
 * msr_kernel_model: receiving kernel that latches result phase 0.
 * assumes phase0 is stable while phase0_valid is high for one cycle.
 */
`timescale 1ns/10ps
`default_nettype none
module msr_kernel_model (
    input  wire logic         core_clk,     // engine clock
    input  wire logic         arst_n,       // async reset, low
    input  wire logic [255:0] phase0,       // header from the engine
    input  wire logic         phase0_valid, // one-cycle pulse
    output var logic  [255:0] msg_r,        // latched header
    output var logic          got_r         // latched this cycle
);
    // whole phase kept; field selection per message type is the reader's job
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            msg_r <= 256'h0;
            got_r <= 1'b0;
        end else begin
            got_r <= phase0_valid;
            if (phase0_valid) begin
                msg_r <= phase0;
            end
        end
    end
endmodule : msr_kernel_model
`default_nettype wire

// File: tb_msr_header.sv
/*
 * tb_msr_header: self-checking bench for the result header builder.
 * assumes msr_pkg, msr_header and msr_kernel_model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) num_checks++; \
    if ((gt) !== (ex)) begin \
        error_cnt++; \
        $display("unexpected %s exp %h got %h", nm, ex, gt); \
    end
module tb_msr_header;
    import msr_pkg::*;
    logic          core_clk = 1'b0;
    logic          arst_n = 1'b0;
    logic          start = 1'b0;
    logic          busy = 1'b0;
    logic          stalled = 1'b0;
    logic          done = 1'b0;
    msr_result_s   result = '0;
    msr_request_s  req = '0;
    logic [255:0]  phase0;
    logic          phase0_valid;
    logic          counting;
    logic [255:0]  msg_r;
    logic          got_r;
    logic [255:0]  exp_q[$];
    logic [255:0]  mon_e;
    int            error_cnt = 0;
    int            num_checks = 0;
    int            seed = 47270;
    int            cyc = 0;

    msr_header u_msr_header (.core_clk(core_clk), .arst_n(arst_n),
        .start(start), .busy(busy), .stalled(stalled), .done(done),
        .result(result), .req(req), .phase0(phase0),
        .phase0_valid(phase0_valid), .counting(counting));
    msr_kernel_model u_msr_kernel_model (.core_clk(core_clk),
        .arst_n(arst_n), .phase0(phase0), .phase0_valid(phase0_valid),
        .msg_r(msg_r), .got_r(got_r));

    always #2.5 core_clk = ~core_clk;

    function automatic logic [255:0] exp_hdr(msr_result_s r, msr_request_s q,
                                             logic [15:0] st, logic [15:0] cp);
        logic        off;
        logic [16:0] cs;
        logic [7:0]  pm;
        logic [63:0] lm;
        logic        xf;
        off = q.intra_compute_select[1];
        cs  = {1'b0, r.chroma_dist_cb} + {1'b0, r.chroma_dist_cr};
        case (r.inter_partition_mode)
            MSR_PART_16X16: pm = r.sub_partition_pred_modes & 8'h03;
            MSR_PART_8X8:   pm = r.sub_partition_pred_modes;
            default:        pm = r.sub_partition_pred_modes & 8'h0f;
        endcase
        lm = off ? 64'h0 : r.luma_pred_modes;
        if (r.intra_partition_mode == MSR_IMODE_16X16) begin
            lm = lm & {4{16'h0003}};
        end
        // intra blocks never fall back to the inter transform rule
        if (!r.luma_16x16) xf = 1'b0;
        else if (r.intra_block_flag)
            xf = r.intra_partition_mode == MSR_IMODE_8X8;
        else xf = q.large_transform_inter_enable && !r.any_sub_lt_8x8;
        return {st, cp,
            r.dual_path ? r.alt_path_units : 6'h0,
            r.mv_limit_hit & r.luma_16x16, r.early_stop_hit, pm,
            r.inter_partition_mode == MSR_PART_8X8 ?
                r.sub_partition_shapes : 8'h0,
            off ? 8'h0 : (q.neighbor_avail_mask & 8'h3f), lm,
            off ? 16'h0 : (cs[16] ? 16'hffff : cs[15:0]),
            off ? 16'h0 : r.best_intra_dist,
            q.skip_eval_enable ? r.skip_raw_dist : 16'h0, r.best_inter_dist,
            5'h0, r.ref1_distortion_sum[26:16], r.path_units,
            r.border_ref1, r.border_ref0,
            3'h0, r.motion_vector_count > 6'h20 ? 5'h0 :
                r.motion_vector_count[4:0], 3'h0,
            off ? 5'h0 : r.intra_block_type_code, xf, q.source_field_access,
            1'b0, r.inter_block_type_code, 8'h0};
    endfunction : exp_hdr

    task automatic draw(output msr_result_s r, output msr_request_s q);
        logic [255:0] rnd;
        for (int i = 0; i < 8; i++) rnd[i*32+:32] = $random(seed);
        r = msr_result_s'(rnd[$bits(msr_result_s)-1:0]);
        q = msr_request_s'(rnd[255:256-$bits(msr_request_s)]);
        r.alt_path_units = 6'({$random(seed)} % 49);
        r.motion_vector_count = 6'({$random(seed)} % 36);
        if (r.intra_partition_mode == MSR_IMODE_16X16)
            r.intra_block_flag = 1'b1;
    endtask : draw

    // pre busy cycles before a second start are counted, then must be cleared by that start
    task automatic request(input int nb, input int pre, input bit all_st);
        logic [15:0]  st;
        logic [15:0]  cp;
        logic         s;
        msr_result_s  r;
        msr_request_s q;
        st = 16'h0;
        cp = 16'h0;
        for (int k = 0; k < (pre > 0 ? 2 : 1); k++) begin
            start = 1'b1;
            @(negedge core_clk);
            start = 1'b0;
            for (int i = 0; i < (k == 0 && pre > 0 ? pre : 0); i++) begin
                busy = 1'b1;
                stalled = $random(seed);
                @(negedge core_clk);
            end
        end
        for (int i = 0; i < nb; i++) begin
            s = all_st | $random(seed);
            busy = 1'b1;
            stalled = s;
            if (s && st != 16'hffff) st++;
            if (!s && cp != 16'hffff) cp++;
            @(negedge core_clk);
            if (i == 0) begin
                `CHK("counting", 1'b1, counting)
            end
        end
        busy = 1'b0;
        stalled = 1'b0;
        draw(r, q);
        result = r;
        req = q;
        done = 1'b1;
        exp_q.push_back(exp_hdr(r, q, st, cp));
        @(negedge core_clk);
        done = 1'b0;
    endtask : request

    task automatic settle(input string nm);
        repeat (4) @(negedge core_clk);
        `CHK("pending results", 0, exp_q.size())
        `CHK("counting idle", 1'b0, counting)
        $display("test %s done, errors %0d", nm, error_cnt);
    endtask : settle

    // read at the falling edge, once the kernel latch has settled
    always @(negedge core_clk) begin
        if (got_r && exp_q.size() == 0) begin
            error_cnt++;
            $display("unexpected phase0 exp none got %h", msg_r);
        end else if (got_r) begin
            mon_e = exp_q.pop_front();
            `CHK("w0.7", mon_e[255:224], msg_r[255:224])
            `CHK("w0.6h", mon_e[223:208], msg_r[223:208])
            `CHK("w0.6l", mon_e[207:192], msg_r[207:192])
            `CHK("w0.5 w0.4", mon_e[191:128], msg_r[191:128])
            `CHK("w0.3", mon_e[127:96], msg_r[127:96])
            `CHK("w0.2", mon_e[95:64], msg_r[95:64])
            `CHK("w0.1", mon_e[63:32], msg_r[63:32])
            `CHK("w0.0", mon_e[31:0], msg_r[31:0])
        end
    end

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize

    // saturation run dominates the budget
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            $display("unexpected timeout exp finish got hang");
            summarize();
        end
    end

    initial begin
        repeat (6) @(negedge core_clk);
        arst_n = 1'b1;
        request(2, 0, 1'b0);
        request(0, 0, 1'b0);
        settle("walk");
        request(3, 5, 1'b0);
        settle("restart");
        for (int t = 0; t < 40; t++) request(t % 7, 0, 1'b0);
        settle("random");
        // a stray done while idle must not produce a header
        done = 1'b1;
        @(negedge core_clk);
        done = 1'b0;
        settle("refused");
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
        busy = 1'b1;
        repeat (3) @(negedge core_clk);
        busy = 1'b0;
        arst_n = 1'b0;
        @(negedge core_clk);
        `CHK("phase0 reset", 256'h0, phase0)
        `CHK("valid reset", 1'b0, phase0_valid)
        `CHK("counting reset", 1'b0, counting)
        arst_n = 1'b1;
        request(4, 0, 1'b0);
        settle("reset");
        request(66000, 0, 1'b1);
        settle("saturate");
        summarize();
    end
endmodule : tb_msr_header
`default_nettype wire
